// ===== inc/trs_pkg.sv
// Constants and types for the touch report select and calibration block.
// Assumes requests arrive already parsed from the control endpoint setup and data stages.
package trs_pkg;
   // ----------------------------------------
   // Request header and data stage codes
   // ----------------------------------------
   localparam logic [7:0] RQT_SET = 8'h21;
   localparam logic [7:0] REQ_SET_REPORT = 8'h09;
   localparam logic [15:0] VAL_FEATURE_3 = 16'h0303;
   localparam logic [15:0] IDX_ZERO = 16'h0000;
   localparam logic [15:0] LEN_EIGHT = 16'h0008;
   localparam logic [7:0] FEATURE_ID = 8'h03;
   localparam logic [7:0] SUB_SELECT = 8'h05;
   localparam logic [7:0] SUB_CALIBRATE = 8'h04;
   localparam logic [7:0] SEL_OFF = 8'h00;
   localparam logic [7:0] SEL_ON = 8'h01;
   localparam logic [7:0] SEL_HID = 8'h02;
   localparam logic [7:0] SEL_PACKED = 8'h03;
   localparam logic [7:0] SEL_UTILITY = 8'h06;
   localparam logic [7:0] SEL_RESTORE = 8'h07;
   localparam logic [7:0] CAL_EXTENDED = 8'h01;
   localparam logic [7:0] CAL_CORNER = 8'h02;
   // ----------------------------------------
   // Command status codes
   // ----------------------------------------
   localparam logic [7:0] ST_FAIL = 8'h00;
   localparam logic [7:0] ST_WAIT_LL = 8'h01;
   localparam logic [7:0] ST_WAIT_UR = 8'h02;
   localparam logic [7:0] ST_DONE = 8'h03;
   localparam logic [7:0] ST_SOFT_RESET = 8'h04;
   // ----------------------------------------
   // Report identifiers
   // ----------------------------------------
   localparam logic [7:0] STANDARD_REPORT_ID = 8'h01; // Value is arbitrary
   localparam logic [7:0] PACKED_REPORT_ID = 8'h02;
   localparam logic [7:0] UTILITY_REPORT_ID = 8'h07;
   // ----------------------------------------
   // Coordinate mapping
   // ----------------------------------------
   localparam logic [11:0] RAW_MAX = 12'hfff;
   localparam logic [11:0] RAW_HALF = 12'h800;
   localparam logic [9:0] TGT_LO = 10'h080;
   localparam logic [9:0] TGT_HI = 10'h37f;
   localparam logic [15:0] OUT_LO = {TGT_LO, 6'h00};
   localparam logic [15:0] OUT_HI = {TGT_HI, 6'h00};
   localparam logic [15:0] COORD_MIN = 16'h0000;
   localparam logic [15:0] COORD_MAX = 16'hffff;
   localparam int GAIN_FRAC = 4;
   localparam logic [19:0] CAL_NUM = {16'(OUT_HI - OUT_LO), 4'h0};
   localparam logic [11:0] DEF_BASE = {TGT_LO, 2'b00};
   localparam logic [19:0] DEF_GAIN = 20'(CAL_NUM / 20'({TGT_HI, 2'b00} - {TGT_LO, 2'b00}));
   localparam logic [4:0] DIV_STEPS = 5'h14;
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_WAIT_LL = 2'b01,
      CAL_WAIT_UR = 2'b11,
      CAL_DIVIDE = 2'b10
   } trs_cal_state_type;
endpackage

// ===== logic/trs_touch_cmd.sv
// Report selection and two point calibration for a resistive touch controller.
// Assumes request fields, reset requests and touch samples come from logic on sys_clk.
`timescale 1ns/10ps
module trs_touch_cmd
   import trs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic req_valid,
   input wire logic [7:0] req_type,
   input wire logic [7:0] req_code,
   input wire logic [15:0] req_value,
   input wire logic [15:0] req_index,
   input wire logic [15:0] req_length,
   input wire logic [7:0] req_byte0,
   input wire logic [7:0] req_byte1,
   input wire logic [7:0] req_byte2,
   input wire logic [7:0] req_byte4,
   input wire logic reset_req,
   input wire logic touch_valid,
   input wire logic [11:0] touch_x,
   input wire logic [11:0] touch_y,
   output logic ep0_ack,
   output logic ep0_stall,
   output logic int_rpt_valid,
   output logic [7:0] int_rpt_id,
   output logic ctl_rpt_valid,
   output logic [15:0] rpt_x,
   output logic [15:0] rpt_y,
   output logic [7:0] cmd_status,
   output logic reports_on,
   output logic packed_sel,
   output logic utility_mode,
   output logic nvm_wr,
   output logic nvm_mirror_x,
   output logic nvm_mirror_y
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic hdr_ok, sel_cmd, cal_cmd, sel_ok, cal_ok, quiet, cal_idle, ll_take, ur_take, ur_bad, div_done;
   trs_cal_state_type state_reg, state_next;
   logic [4:0] step_reg;
   logic [19:0] num_reg, quo_reg [2], gain_reg [2];
   logic on_reg, packed_reg, util_reg, ack_reg, stall_reg, int_vld_reg, ctl_vld_reg, nvm_wr_reg;
   logic [7:0] status_reg, int_id_reg;
   logic [11:0] raw [2], p1_reg [2], span_reg [2], base_reg [2];
   logic mir_reg [2], mir_act_reg [2];
   logic [12:0] rem_reg [2];
   logic [15:0] coord_next [2], coord_reg [2];
   logic [1:0] opp;
   default clocking cb_sys @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   assign raw[0] = touch_x;
   assign raw[1] = touch_y;
   assign hdr_ok = req_type == RQT_SET && req_code == REQ_SET_REPORT && req_value == VAL_FEATURE_3
                   && req_index == IDX_ZERO && req_length == LEN_EIGHT;
   assign sel_cmd = req_valid && hdr_ok && req_byte1 == SUB_SELECT;
   assign cal_cmd = req_valid && hdr_ok && req_byte1 == SUB_CALIBRATE;
   // Unknown selectors count as unprocessable
   assign sel_ok = req_byte0 == FEATURE_ID
                   && req_byte4 inside {SEL_OFF, SEL_ON, SEL_HID, SEL_PACKED, SEL_UTILITY, SEL_RESTORE};
   assign cal_ok = req_byte2 inside {CAL_EXTENDED, CAL_CORNER};
   // Commands take priority; a touch in the same cycle is dropped by the calibration
   assign quiet = !sel_cmd && !cal_cmd && !reset_req;
   assign cal_idle = state_reg == CAL_IDLE;
   assign ll_take = quiet && state_reg == CAL_WAIT_LL && touch_valid;
   assign ur_take = quiet && state_reg == CAL_WAIT_UR && touch_valid && (&opp);
   assign ur_bad = quiet && state_reg == CAL_WAIT_UR && touch_valid && !(&opp);
   assign div_done = quiet && state_reg == CAL_DIVIDE && step_reg == DIV_STEPS;

   // ----------------------------------------
   // Report selection
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         on_reg <= 1'b1;
         packed_reg <= 1'b0;
         util_reg <= 1'b0;
      end else if (reset_req) begin
         on_reg <= 1'b1;
         packed_reg <= 1'b0;
         util_reg <= 1'b0;
      end else if (sel_cmd && sel_ok) begin
         unique case (req_byte4)
            SEL_OFF: on_reg <= 1'b0;
            SEL_ON: on_reg <= 1'b1;
            SEL_HID: begin
               packed_reg <= 1'b0;
               util_reg <= 1'b0;
            end
            SEL_PACKED: begin
               packed_reg <= 1'b1;
               util_reg <= 1'b0;
            end
            SEL_UTILITY: util_reg <= 1'b1;
            // The normal choice is kept while in utility mode, so restore brings it back
            SEL_RESTORE: util_reg <= 1'b0;
            default: ;
         endcase
      end
   end
   a_select_replaces: assert property (sel_cmd && sel_ok && req_byte4 == SEL_PACKED && !reset_req
      |=> packed_sel && !utility_mode) else $error("packed selection did not replace active report");
   a_reset_default: assert property (reset_req |=> reports_on && !packed_sel && !utility_mode)
      else $error("reset did not restore the standard report");
   a_bad_select: assert property (sel_cmd && !sel_ok && !reset_req
      |=> ep0_stall && !ep0_ack && $stable(packed_sel) && $stable(utility_mode) && $stable(reports_on))
      else $error("bad selection not stalled or changed the report");

   // ----------------------------------------
   // Responses and command status
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
         stall_reg <= 1'b0;
         nvm_wr_reg <= 1'b0;
      end else begin
         ack_reg <= (sel_cmd && sel_ok) || (cal_cmd && cal_ok);
         stall_reg <= (sel_cmd && !sel_ok) || (cal_cmd && !cal_ok);
         nvm_wr_reg <= div_done;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         status_reg <= ST_DONE;
      end else if (reset_req) begin
         status_reg <= ST_SOFT_RESET;
      end else if (sel_cmd) begin
         status_reg <= sel_ok ? ST_DONE : ST_FAIL;
      end else if (cal_cmd) begin
         status_reg <= cal_ok ? ST_WAIT_LL : ST_FAIL;
      end else if (ll_take) begin
         status_reg <= ST_WAIT_UR;
      end else if (ur_bad) begin
         status_reg <= ST_FAIL;
      end else if (div_done) begin
         status_reg <= ST_DONE;
      end
   end
   a_bad_cal: assert property (cal_cmd && !cal_ok && !reset_req
      |=> ep0_stall && cmd_status == ST_FAIL && state_reg == CAL_IDLE)
      else $error("bad calibration type not refused");

   // ----------------------------------------
   // Calibration sequencer
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      if (reset_req) begin
         state_next = CAL_IDLE;
      end else if (cal_cmd) begin
         state_next = cal_ok ? CAL_WAIT_LL : CAL_IDLE;
      end else begin
         unique case (state_reg)
            CAL_IDLE: state_next = CAL_IDLE;
            CAL_WAIT_LL: if (ll_take) state_next = CAL_WAIT_UR;
            CAL_WAIT_UR: begin
               if (ur_take) begin
                  state_next = CAL_DIVIDE;
               end else if (ur_bad) begin
                  state_next = CAL_IDLE;
               end
            end
            CAL_DIVIDE: if (div_done) state_next = CAL_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= CAL_IDLE;
         step_reg <= 5'h00;
         num_reg <= 20'h00000;
      end else begin
         state_reg <= state_next;
         step_reg <= (state_reg == CAL_DIVIDE && state_next == CAL_DIVIDE)
                     ? step_reg + 5'(step_reg != DIV_STEPS) : 5'h00;
         num_reg <= ur_take ? CAL_NUM : {num_reg[18:0], 1'b0};
      end
   end

   sequence s_cal_start;
      cal_cmd && cal_ok && !reset_req;
   endsequence
   sequence s_lower_left;
      ll_take;
   endsequence
   a_cal_start: assert property (s_cal_start |=> cmd_status == ST_WAIT_LL && state_reg == CAL_WAIT_LL)
      else $error("accepted calibration did not wait for lower-left");
   a_cal_second: assert property (s_lower_left |=> cmd_status == ST_WAIT_UR && state_reg == CAL_WAIT_UR)
      else $error("lower-left touch did not advance");
   a_quadrant_fail: assert property (ur_bad |=> cmd_status == ST_FAIL && state_reg == CAL_IDLE && !nvm_wr)
      else $error("wrong quadrant did not fail calibration");
   a_abort: assert property (reset_req |=> state_reg == CAL_IDLE && cmd_status == ST_SOFT_RESET)
      else $error("reset did not abandon calibration");
   a_divide_ends: assert property (ur_take |=> state_reg == CAL_DIVIDE ##[20:21] state_reg != CAL_DIVIDE)
      else $error("calibration divide overran");
   a_success_saves: assert property (div_done |=> nvm_wr && cmd_status == ST_DONE ##1 !nvm_wr)
      else $error("success not saved or status wrong");

   // ----------------------------------------
   // Per axis calibration and mapping
   // ----------------------------------------
   for (genvar a = 0; a < 2; a++) begin : g_axis
      logic [11:0] m_cal, m_run;
      logic [12:0] trial;
      logic signed [12:0] dlt;
      logic signed [33:0] prod, val;
      // First touch fixes the mirror; the second must land in the opposite quadrant
      assign m_cal = mir_reg[a] ? RAW_MAX - raw[a] : raw[a];
      assign m_run = mir_act_reg[a] ? RAW_MAX - raw[a] : raw[a];
      assign opp[a] = m_cal >= RAW_HALF;
      assign trial = {rem_reg[a][11:0], num_reg[19]};
      assign dlt = $signed({1'b0, m_run}) - $signed({1'b0, base_reg[a]});
      assign prod = dlt * $signed({1'b0, gain_reg[a]});
      assign val = (prod >>> GAIN_FRAC) + $signed({18'h00000, OUT_LO});
      // Saturate so the output never wraps outside the full scale
      assign coord_next[a] = val[33] ? COORD_MIN : (|val[32:16] ? COORD_MAX : val[15:0]);

      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            mir_reg[a] <= 1'b0;
            p1_reg[a] <= 12'h000;
            span_reg[a] <= 12'h001;
            rem_reg[a] <= 13'h0000;
            quo_reg[a] <= 20'h00000;
         end else begin
            if (ll_take) begin
               mir_reg[a] <= raw[a] >= RAW_HALF;
               p1_reg[a] <= (raw[a] >= RAW_HALF) ? RAW_MAX - raw[a] : raw[a];
            end
            if (ur_take) begin
               span_reg[a] <= m_cal - p1_reg[a];
               rem_reg[a] <= 13'h0000;
               quo_reg[a] <= 20'h00000;
            end else if (state_reg == CAL_DIVIDE && step_reg != DIV_STEPS) begin
               if (trial >= {1'b0, span_reg[a]}) begin
                  rem_reg[a] <= trial - {1'b0, span_reg[a]};
                  quo_reg[a] <= {quo_reg[a][18:0], 1'b1};
               end else begin
                  rem_reg[a] <= trial;
                  quo_reg[a] <= {quo_reg[a][18:0], 1'b0};
               end
            end
         end
      end

      // Mapping only changes on success, so a failed or aborted run keeps the old one
      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            base_reg[a] <= DEF_BASE;
            gain_reg[a] <= DEF_GAIN;
            mir_act_reg[a] <= 1'b0;
         end else if (div_done) begin
            base_reg[a] <= p1_reg[a];
            gain_reg[a] <= quo_reg[a];
            mir_act_reg[a] <= mir_reg[a];
         end
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            coord_reg[a] <= COORD_MIN;
         end else if (touch_valid) begin
            coord_reg[a] <= coord_next[a];
         end
      end
   end

   // ----------------------------------------
   // Report streaming
   // ----------------------------------------
   // Touches are consumed by the calibration while it runs
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         int_vld_reg <= 1'b0;
         ctl_vld_reg <= 1'b0;
         int_id_reg <= STANDARD_REPORT_ID;
      end else begin
         int_vld_reg <= touch_valid && on_reg && !util_reg && cal_idle;
         ctl_vld_reg <= touch_valid && util_reg && cal_idle;
         int_id_reg <= packed_reg ? PACKED_REPORT_ID : STANDARD_REPORT_ID;
      end
   end
   a_report_sent: assert property (touch_valid && on_reg && !util_reg && cal_idle
      |=> int_rpt_valid && !ctl_rpt_valid) else $error("enabled report not sent");
   a_utility_quiet: assert property (util_reg && touch_valid && cal_idle
      |=> ctl_rpt_valid && !int_rpt_valid) else $error("utility mode used interrupt endpoint");

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign ep0_ack = ack_reg;
   assign ep0_stall = stall_reg;
   assign int_rpt_valid = int_vld_reg;
   assign int_rpt_id = int_id_reg;
   assign ctl_rpt_valid = ctl_vld_reg;
   assign rpt_x = coord_reg[0];
   assign rpt_y = coord_reg[1];
   assign cmd_status = status_reg;
   assign reports_on = on_reg;
   assign packed_sel = packed_reg;
   assign utility_mode = util_reg;
   assign nvm_wr = nvm_wr_reg;
   assign nvm_mirror_x = mir_act_reg[0];
   assign nvm_mirror_y = mir_act_reg[1];
endmodule

// ===== dv/trs_host_model.sv
// Host side model: issues parsed set-report requests and reset commands, polls the status byte.
// Assumes the bench calls its tasks and that the block samples requests on the rising sys_clk edge.
`timescale 1ns/10ps
module trs_host_model
   import trs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic ep0_ack,
   input wire logic ep0_stall,
   input wire logic [7:0] cmd_status,
   output logic req_valid,
   output logic [7:0] req_type,
   output logic [7:0] req_code,
   output logic [15:0] req_value,
   output logic [15:0] req_index,
   output logic [15:0] req_length,
   output logic [7:0] req_byte0,
   output logic [7:0] req_byte1,
   output logic [7:0] req_byte2,
   output logic [7:0] req_byte4,
   output logic reset_req
);
   logic got_ack;
   logic got_stall;

   initial begin
      req_valid = 1'b0;
      reset_req = 1'b0;
      {req_type, req_code, req_value, req_index, req_length} = '0;
      {req_byte0, req_byte1, req_byte2, req_byte4} = '0;
   end

   task automatic send(input logic [7:0] sub, input logic [7:0] b2, input logic [7:0] b4);
      send_any(sub, b2, b4, FEATURE_ID, LEN_EIGHT);
   endtask

   // Odd byte 0 or length lets the bench reach the refuse and ignore paths
   task automatic send_any(input logic [7:0] sub, input logic [7:0] b2, input logic [7:0] b4, input logic [7:0] b0,
      input logic [15:0] len);
      @(posedge sys_clk);
      #1;
      req_valid = 1'b1;
      req_type = RQT_SET;
      req_code = REQ_SET_REPORT;
      req_value = VAL_FEATURE_3;
      req_index = IDX_ZERO;
      req_length = len;
      req_byte0 = b0;
      req_byte1 = sub;
      req_byte2 = b2;
      req_byte4 = b4;
      @(posedge sys_clk);
      #1;
      req_valid = 1'b0;
      // Released fields must not keep showing the old request
      {req_type, req_code, req_value, req_index, req_length} = ~{req_type, req_code, req_value, req_index, req_length};
      {req_byte0, req_byte1, req_byte2, req_byte4} = ~{req_byte0, req_byte1, req_byte2, req_byte4};
      got_ack = ep0_ack;
      got_stall = ep0_stall;
   endtask

   task automatic send_reset();
      @(posedge sys_clk);
      #1;
      reset_req = 1'b1;
      @(posedge sys_clk);
      #1;
      reset_req = 1'b0;
   endtask

   task automatic poll(input logic [7:0] code, input int max_cycles, output int waited);
      waited = 0;
      while (cmd_status !== code && waited < max_cycles) begin
         @(posedge sys_clk);
         #1;
         waited++;
      end
   endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the touch report select and calibration block.
// Assumes the host model drives requests; this bench drives clock, reset and touch samples.
`timescale 1ns/10ps
module tb_top;
   import trs_pkg::*;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam logic [7:0] SEL_SEQ [9] = '{SEL_PACKED, SEL_UTILITY, SEL_RESTORE, SEL_HID, SEL_OFF,
      SEL_UTILITY, SEL_RESTORE, SEL_ON, 8'h04};
   logic sys_clk, arst_n, touch_valid, req_valid, reset_req, ep0_ack, ep0_stall, int_rpt_valid, ctl_rpt_valid;
   logic [11:0] touch_x, touch_y;
   logic [7:0] req_type, req_code, req_byte0, req_byte1, req_byte2, req_byte4, int_rpt_id, cmd_status;
   logic [15:0] req_value, req_index, req_length, rpt_x, rpt_y;
   logic reports_on, packed_sel, utility_mode, nvm_wr, nvm_mirror_x, nvm_mirror_y;
   logic [2:0] modes;
   int num_errors = 0;
   int samples_checked = 0;

   trs_touch_cmd dut (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid), .req_type(req_type),
      .req_code(req_code), .req_value(req_value), .req_index(req_index), .req_length(req_length),
      .req_byte0(req_byte0), .req_byte1(req_byte1), .req_byte2(req_byte2), .req_byte4(req_byte4),
      .reset_req(reset_req), .touch_valid(touch_valid), .touch_x(touch_x), .touch_y(touch_y),
      .ep0_ack(ep0_ack), .ep0_stall(ep0_stall), .int_rpt_valid(int_rpt_valid), .int_rpt_id(int_rpt_id),
      .ctl_rpt_valid(ctl_rpt_valid), .rpt_x(rpt_x), .rpt_y(rpt_y), .cmd_status(cmd_status),
      .reports_on(reports_on), .packed_sel(packed_sel), .utility_mode(utility_mode), .nvm_wr(nvm_wr),
      .nvm_mirror_x(nvm_mirror_x), .nvm_mirror_y(nvm_mirror_y));
   trs_host_model host (.sys_clk(sys_clk), .ep0_ack(ep0_ack), .ep0_stall(ep0_stall), .cmd_status(cmd_status),
      .req_valid(req_valid), .req_type(req_type), .req_code(req_code), .req_value(req_value),
      .req_index(req_index), .req_length(req_length), .req_byte0(req_byte0), .req_byte1(req_byte1),
      .req_byte2(req_byte2), .req_byte4(req_byte4), .reset_req(reset_req));

   initial begin
      sys_clk = 1'b0;
      forever begin
         #5 sys_clk = ~sys_clk;
      end
   end
   // ----------------------------------------
   // Expectations and checks
   // ----------------------------------------
   // Mapping before any calibration
   function automatic logic [15:0] def_map(input logic [11:0] raw);
      int v;
      v = int'(OUT_LO) + (int'(raw) - int'(DEF_BASE)) * int'(DEF_GAIN) / (2 ** GAIN_FRAC);
      return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : 16'(v);
   endfunction
   // Next {on, packed, utility}; an unknown code leaves them alone
   function automatic logic [2:0] next_modes(input logic [7:0] c, input logic [2:0] m);
      case (c)
         SEL_OFF: return {1'b0, m[1:0]};
         SEL_ON: return {1'b1, m[1:0]};
         SEL_HID: return {m[2], 2'b00};
         SEL_PACKED: return {m[2], 2'b10};
         SEL_UTILITY: return {m[2:1], 1'b1};
         SEL_RESTORE: return {m[2:1], 1'b0};
         default: return m;
      endcase
   endfunction
   task automatic chk_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic touch(input logic [11:0] x, input logic [11:0] y);
      @(posedge sys_clk);
      #1;
      touch_valid = 1'b1;
      touch_x = x;
      touch_y = y;
      @(posedge sys_clk);
      #1;
      touch_valid = 1'b0;
      touch_x = ~x;
      touch_y = ~y;
   endtask
   task automatic stream_chk();
      logic [11:0] x, y;
      x = 12'($urandom());
      y = 12'($urandom());
      touch(x, y);
      chk_flag(int_rpt_valid, modes[2] & ~modes[0]);
      chk_flag(ctl_rpt_valid, modes[0]);
      if (int_rpt_valid === 1'b1) begin
         chk_word(16'(int_rpt_id), modes[1] ? 16'(PACKED_REPORT_ID) : 16'(STANDARD_REPORT_ID));
      end
      chk_word(rpt_x, def_map(x));
      chk_word(rpt_y, def_map(y));
   endtask
   task automatic end_test(input string name);
      $display("test %s finished, %0d mismatches so far", name, num_errors);
   endtask
   task automatic summarize();
      $display("checked %0d samples, %0d mismatches", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      #100000;
      num_errors++;
      summarize();
   end
   initial begin
      logic [7:0] c;
      logic [11:0] px [2];
      logic [11:0] py [2];
      int waited;
      arst_n = 1'b0;
      touch_valid = 1'b0;
      touch_x = 12'h000;
      touch_y = 12'h000;
      modes = 3'b100;
      c = 8'($urandom(32428));
      repeat (5) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      chk_word(16'({reports_on, packed_sel, utility_mode}), 16'h0004);
      chk_word(16'(int_rpt_id), 16'(STANDARD_REPORT_ID));
      touch(DEF_BASE, {TGT_HI, 2'b00});
      chk_word(rpt_x, OUT_LO);
      chk_word(rpt_y, OUT_HI);
      end_test("defaults");
      for (int i = 0; i < 13; i++) begin
         c = (i < 9) ? SEL_SEQ[i] : 8'($urandom_range(32'hff, 32'h08));
         host.send(SUB_SELECT, 8'h00, c);
         modes = next_modes(c, modes);
         chk_flag(host.got_stall, i >= 8);
         chk_flag(host.got_ack, i < 8);
         chk_word(16'(cmd_status), (i < 8) ? 16'(ST_DONE) : 16'(ST_FAIL));
         chk_word(16'({reports_on, packed_sel, utility_mode}), 16'(modes));
         stream_chk();
      end
      end_test("report select");
      for (int i = 0; i < 3; i++) begin
         c = (i == 0) ? 8'h00 : (i == 1) ? 8'h03 : 8'($urandom_range(32'hff, 32'h03));
         host.send(SUB_CALIBRATE, c, 8'h00);
         chk_flag(host.got_stall, 1'b1);
         chk_word(16'(cmd_status), 16'(ST_FAIL));
      end
      for (int i = 0; i < 2; i++) begin
         px[i] = 12'($urandom_range(32'h700, 32'h100));
         py[i] = 12'($urandom_range(32'h700, 32'h100));
         px[1 - i] = 12'($urandom_range(32'hf00, 32'h900));
         py[1 - i] = 12'($urandom_range(32'hf00, 32'h900));
         host.send(SUB_CALIBRATE, (i == 0) ? CAL_EXTENDED : CAL_CORNER, 8'h00);
         chk_word(16'(cmd_status), 16'(ST_WAIT_LL));
         touch(px[0], py[0]);
         chk_flag(int_rpt_valid | ctl_rpt_valid, 1'b0);
         chk_word(16'(cmd_status), 16'(ST_WAIT_UR));
         touch(px[1], py[1]);
         host.poll(ST_DONE, 40, waited);
         chk_word(16'(waited), 16'h0015);
         chk_word(16'(cmd_status), 16'(ST_DONE));
         chk_flag(nvm_wr, 1'b1);
         chk_word(16'({nvm_mirror_x, nvm_mirror_y}), (i == 1) ? 16'h0003 : 16'h0000);
         touch(px[0], py[0]);
         chk_flag(int_rpt_valid, 1'b1);
         chk_word(rpt_x, OUT_LO);
         chk_word(rpt_y, OUT_LO);
         touch(px[1], py[1]);
         chk_flag(rpt_x + 16'h0100 >= OUT_HI && rpt_x <= OUT_HI + 16'h0100, 1'b1);
         chk_flag(rpt_y + 16'h0100 >= OUT_HI && rpt_y <= OUT_HI + 16'h0100, 1'b1);
      end
      end_test("calibration");
      host.send(SUB_CALIBRATE, CAL_CORNER, 8'h00);
      touch(12'h100, 12'h100);
      touch(12'h200, 12'h700);
      chk_word(16'(cmd_status), 16'(ST_FAIL));
      touch(12'h200, 12'h200);
      chk_flag(int_rpt_valid, 1'b1);
      host.send(SUB_SELECT, 8'h00, SEL_PACKED);
      host.send(SUB_CALIBRATE, CAL_EXTENDED, 8'h00);
      touch(12'h100, 12'h100);
      host.send_reset();
      chk_word(16'(cmd_status), 16'(ST_SOFT_RESET));
      chk_word(16'({reports_on, packed_sel, utility_mode}), 16'h0004);
      touch(12'h900, 12'h900);
      chk_flag(int_rpt_valid, 1'b1);
      chk_word(16'(int_rpt_id), 16'(STANDARD_REPORT_ID));
      host.send_any(SUB_SELECT, 8'h00, SEL_UTILITY, 8'h21, LEN_EIGHT);
      chk_flag(host.got_stall, 1'b1);
      chk_word(16'(cmd_status), 16'(ST_FAIL));
      host.send_any(SUB_SELECT, 8'h00, SEL_UTILITY, FEATURE_ID, 16'h0010);
      chk_flag(host.got_ack | host.got_stall, 1'b0);
      chk_word(16'({reports_on, packed_sel, utility_mode}), 16'h0004);
      end_test("fail and abort");
      summarize();
   end
endmodule
